// file: src/comparator_regs.svh
// Register offsets, field positions and reset values for the comparator control block
`ifndef COMPARATOR_REGS_SVH
`define COMPARATOR_REGS_SVH

`define ADDR_COMP0_INPUT_SELECT 8'h9C
`define ADDR_COMP1_CONTROL 8'h9D
`define ADDR_EXT_IRQ_MASK_ONE 8'hE6
`define PAGE_COMPARATOR 8'h00

`define RST_COMP0_INPUT_SELECT 8'h77
`define RST_COMP1_CONTROL 8'h00
`define RST_EXT_IRQ_MASK_ONE 8'h00

`define BIT_COMP1_ON 7
`define BIT_COMP1_OUTPUT_STATE 6
`define BIT_COMP1_RISE_FLAG 5
`define BIT_COMP1_FALL_FLAG 4
`define BIT_COMP1_IRQ_MASK 5
`define BIT_COMP0_IRQ_MASK 4

`define SEL_LAST_PIN 4'hB

`endif

// file: src/comparator_pkg.sv
// Types shared by the comparator control block
package comparator_pkg;
  typedef enum logic [1:0] {
    HYST_OFF,
    HYST_5MV,
    HYST_10MV,
    HYST_20MV
  } hysteresis_t;
endpackage : comparator_pkg

// file: src/comparator_control_and_mux.sv
// Comparator control registers, edge flags, input multiplexers and interrupt requests
//
// Contract
// [R1] Control bit 7 turns comparator 1 on when 1, off when 0.
// [R2] Control bit 6 is read-only and shows the comparator 1 output; the code reads it as 0 while bit 7 is 0.
// [R3] Bit 5 sets on a rising output edge and stays until software writes 0.
// [R4] Bit 4 sets on a falling output edge and stays until software writes 0.
// [R5] Bits 3:2 pick positive hysteresis: off, 5, 10 or 20 mV.
// [R6] Bits 1:0 pick negative hysteresis with the same four codes.
// [R7] Control register sits at 0x9D on page 0x00 and resets to zero.
// [R8] Comparator 0 negative select bits 7:4 route odd pins; codes 1100-1111 none.
// [R9] Comparator 0 positive select bits 3:0 route even pins; codes 1100-1111 none.
// [R10] Mask bit 5 passes comparator 1 edge flags to its interrupt request.
// [R11] Mask bit 4 passes comparator 0 edge flags to its interrupt request.
// [R12] Mask register at 0xE6 answers on every page and resets to zero.
// [R13] Comparator outputs pass two flip-flops before edge detection.
// [R14] A new edge in the clearing write's cycle keeps the flag set.
`timescale 1ns/10ps
`include "comparator_regs.svh"

module comparator_control_and_mux
  import comparator_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic comp0_raw_out,
  input wire logic comp1_raw_out,
  output logic comp1_on,
  output hysteresis_t comp1_pos_hysteresis,
  output hysteresis_t comp1_neg_hysteresis,
  output logic [23:0] comp0_pos_pin_connect,
  output logic [23:0] comp0_neg_pin_connect,
  output logic comp0_irq,
  output logic comp1_irq
);

  logic [7:0] input_select_reg;
  logic [7:0] ext_irq_mask_reg;
  logic comp1_on_reg;
  logic [1:0] pos_hyst_reg;
  logic [1:0] neg_hyst_reg;
  logic comp1_rise_flag_reg;
  logic comp1_fall_flag_reg;
  logic comp0_rise_flag_reg;
  logic comp0_fall_flag_reg;
  logic [1:0] sync0_reg;
  logic [1:0] sync1_reg;
  logic comp0_prev_reg;
  logic comp1_prev_reg;
  logic [23:0] pos_connect_next;
  logic [23:0] neg_connect_next;
  logic page_ok;
  logic wr_select;
  logic wr_control;
  logic wr_mask;
  logic comp1_rise;
  logic comp1_fall;
  logic comp0_rise;
  logic comp0_fall;
  logic [7:0] control_view;

  assign page_ok = (sfr_page == `PAGE_COMPARATOR);
  assign wr_select = sfr_wr && page_ok && (sfr_addr == `ADDR_COMP0_INPUT_SELECT);
  assign wr_control = sfr_wr && page_ok && (sfr_addr == `ADDR_COMP1_CONTROL); // R7
  assign wr_mask = sfr_wr && (sfr_addr == `ADDR_EXT_IRQ_MASK_ONE); // R12

  // Analog outputs are asynchronous; first stage feeds only the second
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sync0_reg <= 2'h0;
      sync1_reg <= 2'h0;
    end else begin
      sync0_reg <= {sync0_reg[0], comp0_raw_out}; // R13
      sync1_reg <= {sync1_reg[0], comp1_raw_out}; // R13
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp0_prev_reg <= 1'b0;
      comp1_prev_reg <= 1'b0;
    end else begin
      comp0_prev_reg <= sync0_reg[1];
      comp1_prev_reg <= sync1_reg[1];
    end
  end

  // A disabled comparator produces no edges
  assign comp1_rise = comp1_on_reg && sync1_reg[1] && !comp1_prev_reg; // R13
  assign comp1_fall = comp1_on_reg && !sync1_reg[1] && comp1_prev_reg; // R13
  assign comp0_rise = sync0_reg[1] && !comp0_prev_reg;
  assign comp0_fall = !sync0_reg[1] && comp0_prev_reg;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp1_on_reg <= 1'b0;
      pos_hyst_reg <= 2'h0;
      neg_hyst_reg <= 2'h0;
    end else if (wr_control) begin
      comp1_on_reg <= sfr_wdata[`BIT_COMP1_ON]; // R1
      pos_hyst_reg <= sfr_wdata[3:2]; // R5
      neg_hyst_reg <= sfr_wdata[1:0]; // R6
    end
  end

  // Writing 1 to a flag leaves it alone; only 0 clears, and an edge wins
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp1_rise_flag_reg <= 1'b0;
      comp1_fall_flag_reg <= 1'b0;
    end else begin
      if (comp1_rise) begin
        comp1_rise_flag_reg <= 1'b1; // R3 R14
      end else if (wr_control && !sfr_wdata[`BIT_COMP1_RISE_FLAG]) begin
        comp1_rise_flag_reg <= 1'b0; // R3
      end
      if (comp1_fall) begin
        comp1_fall_flag_reg <= 1'b1; // R4 R14
      end else if (wr_control && !sfr_wdata[`BIT_COMP1_FALL_FLAG]) begin
        comp1_fall_flag_reg <= 1'b0; // R4
      end
    end
  end

  // Comparator 0 flags live elsewhere; kept here only to feed its request
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp0_rise_flag_reg <= 1'b0;
      comp0_fall_flag_reg <= 1'b0;
    end else begin
      if (comp0_rise) begin
        comp0_rise_flag_reg <= 1'b1;
      end else if (comp0_irq && wr_mask && !sfr_wdata[`BIT_COMP0_IRQ_MASK]) begin
        comp0_rise_flag_reg <= comp0_rise_flag_reg;
      end
      if (comp0_fall) begin
        comp0_fall_flag_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      input_select_reg <= `RST_COMP0_INPUT_SELECT;
    end else if (wr_select) begin
      input_select_reg <= sfr_wdata;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      ext_irq_mask_reg <= `RST_EXT_IRQ_MASK_ONE; // R12
    end else if (wr_mask) begin
      ext_irq_mask_reg <= sfr_wdata;
    end
  end

  // One-hot pin connect: bit 2k is the even pin, bit 2k+1 the odd pin of slot k
  always_comb begin
    pos_connect_next = 24'h000000;
    neg_connect_next = 24'h000000;
    if (input_select_reg[3:0] <= `SEL_LAST_PIN) begin
      pos_connect_next[{input_select_reg[3:0], 1'b0}] = 1'b1; // R9
    end
    if (input_select_reg[7:4] <= `SEL_LAST_PIN) begin
      neg_connect_next[{input_select_reg[7:4], 1'b1}] = 1'b1; // R8
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp0_pos_pin_connect <= 24'h000000;
      comp0_neg_pin_connect <= 24'h000000;
    end else begin
      comp0_pos_pin_connect <= pos_connect_next;
      comp0_neg_pin_connect <= neg_connect_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      comp1_on <= 1'b0;
      comp1_pos_hysteresis <= HYST_OFF;
      comp1_neg_hysteresis <= HYST_OFF;
      comp0_irq <= 1'b0;
      comp1_irq <= 1'b0;
    end else begin
      comp1_on <= comp1_on_reg; // R1
      comp1_pos_hysteresis <= hysteresis_t'(pos_hyst_reg); // R5
      comp1_neg_hysteresis <= hysteresis_t'(neg_hyst_reg); // R6
      comp1_irq <= ext_irq_mask_reg[`BIT_COMP1_IRQ_MASK]
                   && (comp1_rise_flag_reg || comp1_fall_flag_reg); // R10
      comp0_irq <= ext_irq_mask_reg[`BIT_COMP0_IRQ_MASK]
                   && (comp0_rise_flag_reg || comp0_fall_flag_reg); // R11
    end
  end

  assign control_view = {comp1_on_reg, sync1_reg[1] && comp1_on_reg, // R2
                         comp1_rise_flag_reg, comp1_fall_flag_reg,
                         pos_hyst_reg, neg_hyst_reg};

  // Registered read data; unmapped addresses read zero
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sfr_rdata <= 8'h00;
    end else if (sfr_rd) begin
      if (sfr_addr == `ADDR_EXT_IRQ_MASK_ONE) begin
        sfr_rdata <= ext_irq_mask_reg; // R12
      end else if (page_ok && sfr_addr == `ADDR_COMP1_CONTROL) begin
        sfr_rdata <= control_view; // R7
      end else if (page_ok && sfr_addr == `ADDR_COMP0_INPUT_SELECT) begin
        sfr_rdata <= input_select_reg;
      end else begin
        sfr_rdata <= 8'h00;
      end
    end
  end

endmodule : comparator_control_and_mux

// file: test/comparator_pins.sv
// Far-side model: analog comparator outputs seen at the port pins
`timescale 1ns/10ps
module comparator_pins #(
  parameter int SETTLE = 7
) (
  input wire logic [1:0] level_cmd,
  output wire logic comp0_raw_out,
  output wire logic comp1_raw_out
);
  // Settles off the clock grid, as a real analog output would
  assign #(SETTLE) {comp1_raw_out, comp0_raw_out} = level_cmd;
endmodule : comparator_pins

// file: test/comparator_assertions.sv
// Port-level assertions for the comparator control block
`timescale 1ns/10ps
`include "comparator_regs.svh"
module comparator_assertions
  import comparator_pkg::*;
(
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_page,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic comp1_on,
  input wire hysteresis_t comp1_pos_hysteresis,
  input wire hysteresis_t comp1_neg_hysteresis,
  input wire logic [23:0] comp0_pos_pin_connect,
  input wire logic [23:0] comp0_neg_pin_connect,
  input wire logic comp0_irq,
  input wire logic comp1_irq
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic pg, w_ctl, w_sel, w_msk;
  assign pg = sfr_page == `PAGE_COMPARATOR;
  assign w_ctl = sfr_wr && sfr_addr == `ADDR_COMP1_CONTROL && pg;
  assign w_sel = sfr_wr && sfr_addr == `ADDR_COMP0_INPUT_SELECT && pg;
  assign w_msk = sfr_wr && sfr_addr == `ADDR_EXT_IRQ_MASK_ONE;
  function automatic logic [23:0] pin(input logic [3:0] c, input logic odd);
    pin = c <= `SEL_LAST_PIN ? 24'h1 << (2 * c + odd) : 24'h0;
  endfunction : pin
  enable_follows_a: assert property (
    w_ctl |-> ##2 comp1_on == $past(sfr_wdata[7], 2)) else $error("enable mismatch");
  pos_hyst_a: assert property (
    w_ctl |-> ##2 comp1_pos_hysteresis == $past(sfr_wdata[3:2], 2)) else $error("pos hyst");
  neg_hyst_a: assert property (
    w_ctl |-> ##2 comp1_neg_hysteresis == $past(sfr_wdata[1:0], 2)) else $error("neg hyst");
  pos_mux_a: assert property (
    w_sel |-> ##2 comp0_pos_pin_connect == pin($past(sfr_wdata[3:0], 2), 1'b0))
    else $error("pos select");
  neg_mux_a: assert property (
    w_sel |-> ##2 comp0_neg_pin_connect == pin($past(sfr_wdata[7:4], 2), 1'b1))
    else $error("neg select");
  irq1_masked_a: assert property (w_msk && !sfr_wdata[5] |-> ##2 !comp1_irq)
    else $error("comp1 irq not masked");
  irq0_masked_a: assert property (w_msk && !sfr_wdata[4] |-> ##2 !comp0_irq)
    else $error("comp0 irq not masked");
  unmapped_read_a: assert property (
    sfr_rd && !(sfr_addr inside {8'h9C, 8'h9D, 8'hE6}) |=> sfr_rdata == 8'h00)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (!sfr_rd |=> $stable(sfr_rdata)) else $error("rdata moved");
  cover property (w_ctl);
  cover property ($rose(comp1_irq));
  cover property ($rose(comp0_irq));
endmodule : comparator_assertions
bind comparator_control_and_mux comparator_assertions i_chk (.clk, .reset, .sfr_addr,
  .sfr_page, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .comp1_on, .comp1_pos_hysteresis,
  .comp1_neg_hysteresis, .comp0_pos_pin_connect, .comp0_neg_pin_connect, .comp0_irq,
  .comp1_irq);

// file: test/comparator_control_and_mux_bench.sv
// Self-checking bench for the comparator control block
`timescale 1ns/10ps
module comparator_control_and_mux_bench
  import comparator_pkg::*;
;
  logic clk = 0, reset = 1, sfr_wr = 0, sfr_rd = 0, comp1_on, comp0_irq, comp1_irq;
  logic [7:0] sfr_addr = 0, sfr_page = 0, sfr_wdata = 0, sfr_rdata;
  logic [1:0] level_cmd = 0;
  wire comp0_raw_out, comp1_raw_out;
  hysteresis_t comp1_pos_hysteresis, comp1_neg_hysteresis;
  logic [23:0] comp0_pos_pin_connect, comp0_neg_pin_connect;
  int n_errors = 0, samples_checked = 0, cycles = 0;
  always #20 clk = ~clk;
  comparator_pins i_pins (.level_cmd, .comp0_raw_out, .comp1_raw_out);
  comparator_control_and_mux i_dut (.clk, .reset, .sfr_addr, .sfr_page, .sfr_wr, .sfr_rd,
    .sfr_wdata, .sfr_rdata, .comp0_raw_out, .comp1_raw_out, .comp1_on, .comp1_pos_hysteresis,
    .comp1_neg_hysteresis, .comp0_pos_pin_connect, .comp0_neg_pin_connect, .comp0_irq,
    .comp1_irq);
  task chk(input logic [23:0] got, input logic [23:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task wr(input logic [7:0] a, input logic [7:0] p, input logic [7:0] d);
    @(posedge clk);
    sfr_addr <= a;
    sfr_page <= p;
    sfr_wdata <= d;
    sfr_wr <= 1;
    @(posedge clk);
    sfr_wr <= 0;
    repeat (3) @(posedge clk);
    #1;
  endtask : wr
  task rd(input logic [7:0] a, input logic [7:0] p, input logic [7:0] e);
    @(posedge clk);
    sfr_addr <= a;
    sfr_page <= p;
    sfr_rd <= 1;
    @(posedge clk);
    sfr_rd <= 0;
    @(posedge clk);
    #1;
    chk(sfr_rdata, e);
  endtask : rd
  // Edge needs two sync stages, flag and irq registers: six cycles leaves margin
  task settle;
    repeat (6) @(posedge clk);
    #1;
  endtask : settle
  task complete_run;
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : complete_run
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_errors++;
      complete_run();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    reset <= 0;
    @(posedge clk);
    #1;
    chk(comp0_pos_pin_connect, 24'h004000);
    chk(comp0_neg_pin_connect, 24'h008000);
    rd(8'h9C, 8'h00, 8'h77);
    rd(8'h9D, 8'h00, 8'h00);
    rd(8'hE6, 8'h0F, 8'h00);
    for (int c = 0; c < 16; c++) begin
      wr(8'h9C, 8'h00, {c[3:0], c[3:0]});
      chk(comp0_pos_pin_connect, c < 12 ? 24'h1 << (2 * c) : 24'h0);
      chk(comp0_neg_pin_connect, c < 12 ? 24'h2 << (2 * c) : 24'h0);
    end
    for (int h = 0; h < 4; h++) begin
      wr(8'h9D, 8'h00, {4'h8, h[1:0], h[1:0]});
      chk(comp1_pos_hysteresis, h[1:0]);
      chk(comp1_neg_hysteresis, h[1:0]);
      chk(comp1_on, 1'b1);
    end
    wr(8'hE6, 8'h00, 8'h20);
    level_cmd <= 2'b10;
    settle();
    chk(comp1_irq, 1'b1);
    rd(8'h9D, 8'h00, 8'hEF);
    wr(8'h9D, 8'h00, 8'h8F);
    rd(8'h9D, 8'h00, 8'hCF);
    chk(comp1_irq, 1'b0);
    level_cmd <= 2'b00;
    settle();
    rd(8'h9D, 8'h00, 8'h9F);
    // A one on the fall flag bit and on the read-only bit must change nothing
    wr(8'h9D, 8'h00, 8'hDF);
    rd(8'h9D, 8'h00, 8'h9F);
    wr(8'h9D, 8'h00, 8'h8F);
    rd(8'h9D, 8'h00, 8'h8F);
    chk(comp1_irq, 1'b0);
    wr(8'hE6, 8'h0F, 8'h10);
    chk(comp1_irq, 1'b0);
    level_cmd <= 2'b01;
    settle();
    chk(comp0_irq, 1'b1);
    rd(8'hE6, 8'h0F, 8'h10);
    // Clearing write lands on the edge where the synced rise is seen
    level_cmd <= 2'b11;
    @(posedge clk);
    wr(8'h9D, 8'h00, 8'h8F);
    rd(8'h9D, 8'h00, 8'hEF);
    wr(8'h9D, 8'h01, 8'h00);
    chk(comp1_on, 1'b1);
    rd(8'h9D, 8'h01, 8'h00);
    rd(8'h9E, 8'h00, 8'h00);
    wr(8'h9D, 8'h00, 8'h00);
    chk(comp1_on, 1'b0);
    complete_run();
  end
endmodule : comparator_control_and_mux_bench
